/* hdl/rail_cfg_pkg.sv */
// constants and carrier types for the rail configuration register bank
// assumes a byte-wide register port driven by the serial bus front end
package rail_cfg_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CFG_ONE = 8'h13;
   localparam logic [7:0] OFS_CFG_TWO = 8'h14;
   localparam logic [7:0] OFS_CFG_THREE = 8'h15;
   localparam logic [7:0] OFS_BUCK_ONE = 8'h16;
   localparam logic [7:0] OFS_BUCK_TWO = 8'h17;
   localparam logic [7:0] OFS_BUCK_THREE = 8'h18;
   localparam logic [7:0] OFS_BUCKBOOST = 8'h19;
   localparam logic [7:0] OFS_SLEW = 8'h1a;

   // ---------------------------------------------------------------
   // reset values and writable masks
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_CFG_ONE = 8'h4c;
   localparam logic [7:0] RST_CFG_TWO = 8'hc0;
   localparam logic [7:0] RST_CFG_THREE = 8'h00;
   localparam logic [7:0] RST_BUCK_ONE = 8'h99;
   localparam logic [7:0] RST_BUCK_THREE = 8'h8c;
   localparam logic [7:0] RST_BUCKBOOST = 8'hb2;
   localparam logic [7:0] RST_SLEW = 8'h06;
   localparam logic [7:0] WMASK_CFG_ONE = 8'hff;
   localparam logic [7:0] WMASK_CFG_TWO = 8'hcf;
   localparam logic [7:0] WMASK_CFG_THREE = 8'h3f;
   localparam logic [7:0] WMASK_BUCK = 8'hbf;
   localparam logic [7:0] WMASK_SLEW = 8'hc7;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int POS_PG_DELAY = 3;
   localparam int POS_TIGHT = 2;
   localparam int POS_LOCKOUT = 0;
   localparam int POS_WARMRST = 7;
   localparam int POS_HYS = 6;
   localparam int POS_ILIM = 2;
   localparam int POS_PFDIS = 5;
   localparam int POS_DISCH = 2;
   localparam int POS_SKIP = 7;
   localparam int POS_GO = 7;
   localparam int POS_AUTO = 6;
   localparam logic [5:0] BB_LAST_CODE = 6'h34;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int BLANK_MS = 5;
   localparam int PG_MS_0 = 10;
   localparam int PG_MS_1 = 20;
   localparam int PG_MS_2 = 50;
   localparam int PG_MS_3 = 150;
   localparam int CYC_PER_MS = CLK_MHZ * 1000;
   localparam int BLANK_CYC = BLANK_MS * CYC_PER_MS;

   // carrier for a register access
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_req_s;

   // power-good sequencing state
   typedef enum logic [1:0] {PG_LOW = 2'b00, PG_WAIT = 2'b01, PG_HIGH = 2'b11} pg_state_e;

endpackage

/* hdl/rail_config_regs.sv */
// configuration register bank for the buck rails, load switch and supervisor
// assumes the serial front end delivers one decoded access per cycle,
// the unlock procedure is tracked upstream and all inputs share clk_sys
`timescale 1ns/100ps

module rail_config_regs
   import rail_cfg_pkg::*;
#(
   parameter int BLANK_CYCLES = BLANK_CYC,
   parameter int MS_CYCLES = CYC_PER_MS
) (
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clkEn,
   // register access
   input wire reg_req_s regReq,
   input wire logic regStrobe,
   input wire logic unlocked,
   output logic [7:0] regRdata,
   output logic regAck,
   // default selection resistor straps
   input wire logic resistorValid,
   input wire logic [5:0] resistorBuckThree,
   input wire logic [5:0] resistorBuckBoost,
   // transition control from the slew block
   input wire logic transitionDone,
   output logic transitionStart,
   // monitors and analogue status
   input wire logic railsInRegulation,
   input wire logic railFault,
   input wire logic powerfail_out_n,
   input wire logic switchEnable,
   input wire logic gpPinTwoIn,
   // configuration outputs
   output logic powerGood,
   output logic monitorBlank,
   output logic overvoltageMonitorEn,
   output logic supervisorTight,
   output logic [1:0] undervoltageLockoutSel,
   output logic lockoutHysteresisSel,
   output logic [1:0] switchCurrentLimitSel,
   output logic switchOn,
   output logic switchDischarge,
   output logic railPairWarmReset,
   output logic gpPinTwoIsOutput,
   output logic [3:0] pulseSkipEn,
   output logic [5:0] buckOneTarget,
   output logic [5:0] buckTwoTarget,
   output logic [5:0] buckThreeCode,
   output logic [5:0] buckboostCode
);

   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   logic [7:0] cfgOne_q, cfgTwo_q, cfgThree_q, slew_q;
   logic [7:0] buck_q [4];
   logic [5:0] targetOne_q, targetTwo_q;
   logic [31:0] blankCnt_q, pgCnt_q;
   logic [31:0] pgLimit;
   logic strapDone_q, powerGood_q;
   pg_state_e pgState_q;
   logic wrAcc, buckWr, codeWrPair;

   // protected write, taken only once unlocked
   assign wrAcc = regStrobe && regReq.wr && unlocked && clkEn;
   assign buckWr = wrAcc && regReq.addr >= OFS_BUCK_ONE && regReq.addr <= OFS_BUCKBOOST;
   assign codeWrPair = wrAcc && (regReq.addr == OFS_BUCK_ONE || regReq.addr == OFS_BUCK_TWO);

   // masked merge: read-only bits keep their stored value
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                        input logic [7:0] msk);
      merge = (old & ~msk) | (nw & msk);
   endfunction

   // buck register slot from the low address bits; 0x16 lands on slot 0
   function automatic logic [1:0] buck_slot(input logic [7:0] addr);
      buck_slot = addr[1:0] + 2'd2;
   endfunction

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cfgOne_q <= RST_CFG_ONE;
         cfgTwo_q <= RST_CFG_TWO;
         cfgThree_q <= RST_CFG_THREE;
         slew_q <= RST_SLEW;
      end else if (clkEn) begin
         // done is seen even beside another write; a trigger write wins
         if (transitionDone) slew_q[POS_GO] <= 1'b0;
         if (wrAcc) begin
            // reserved read-only bits are masked out
            case (regReq.addr)
               OFS_CFG_ONE: cfgOne_q <= merge(cfgOne_q, regReq.data, WMASK_CFG_ONE);
               OFS_CFG_TWO: cfgTwo_q <= merge(cfgTwo_q, regReq.data, WMASK_CFG_TWO);
               OFS_CFG_THREE: cfgThree_q <= merge(cfgThree_q, regReq.data, WMASK_CFG_THREE);
               OFS_SLEW: slew_q <= merge(slew_q, regReq.data, WMASK_SLEW);
               default: ;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // converter voltage registers
   // ---------------------------------------------------------------
   // straps are sampled once after reset release, never under reset
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         buck_q[0] <= RST_BUCK_ONE;
         buck_q[1] <= RST_BUCK_ONE;
         buck_q[2] <= RST_BUCK_THREE;
         buck_q[3] <= RST_BUCKBOOST;
         strapDone_q <= 1'b0;
      end else if (clkEn) begin
         if (!strapDone_q) begin
            strapDone_q <= 1'b1;
            if (resistorValid) begin
               buck_q[2][5:0] <= resistorBuckThree;
               buck_q[3][5:0] <= resistorBuckBoost;
            end
         end else if (buckWr) begin
            // pulse-skip bit lands here and is used at once
            buck_q[buck_slot(regReq.addr)] <= merge(buck_q[buck_slot(regReq.addr)],
                                                     regReq.data, WMASK_BUCK);
         end
      end
   end

   // ---------------------------------------------------------------
   // buck one/two applied targets
   // ---------------------------------------------------------------
   // stored code reaches the rail only through trigger or auto mode
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         targetOne_q <= RST_BUCK_ONE[5:0];
         targetTwo_q <= RST_BUCK_ONE[5:0];
      end else if (clkEn) begin
         if (slew_q[POS_GO] || slew_q[POS_AUTO]) begin
            targetOne_q <= buck_q[0][5:0];
            targetTwo_q <= buck_q[1][5:0];
         end
      end
   end
   assign transitionStart = slew_q[POS_GO] || (slew_q[POS_AUTO] && codeWrPair);

   // ---------------------------------------------------------------
   // monitor blanking after a voltage write
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         blankCnt_q <= '0;
      end else if (buckWr) begin
         blankCnt_q <= BLANK_CYCLES; // restart on every voltage register write
      end else if (clkEn && blankCnt_q != 0) begin
         blankCnt_q <= blankCnt_q - 32'd1;
      end
   end
   assign monitorBlank = blankCnt_q != 0;

   // ---------------------------------------------------------------
   // power-good delay
   // ---------------------------------------------------------------
   always_comb begin
      case (cfgOne_q[POS_PG_DELAY +: 2])
         2'b00: pgLimit = PG_MS_0 * MS_CYCLES;
         2'b01: pgLimit = PG_MS_1 * MS_CYCLES;
         2'b10: pgLimit = PG_MS_2 * MS_CYCLES;
         default: pgLimit = PG_MS_3 * MS_CYCLES;
      endcase
   end

   // rise waits out the delay, fall drops at once
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pgState_q <= PG_LOW;
         pgCnt_q <= '0;
         powerGood_q <= 1'b0;
      end else if (clkEn) begin
         case (pgState_q)
            PG_LOW: begin
               pgCnt_q <= '0;
               powerGood_q <= 1'b0;
               if (railsInRegulation && !railFault) pgState_q <= PG_WAIT;
            end
            PG_WAIT: begin
               if (!railsInRegulation || railFault) begin
                  pgState_q <= PG_LOW;
               end else if (pgCnt_q + 32'd1 >= pgLimit) begin
                  pgState_q <= PG_HIGH;
                  powerGood_q <= 1'b1;
               end else begin
                  pgCnt_q <= pgCnt_q + 32'd1;
               end
            end
            // flag drops with the state, or a short fault would reappear undelayed
            PG_HIGH: begin
               if (!railsInRegulation || railFault) begin
                  pgState_q <= PG_LOW;
                  powerGood_q <= 1'b0;
               end
            end
            default: begin
               pgState_q <= PG_LOW;
               powerGood_q <= 1'b0;
            end
         endcase
      end
   end
   // combinational drop so power-down shows no delay
   assign powerGood = powerGood_q && railsInRegulation && !railFault;

   // ---------------------------------------------------------------
   // configuration decode to the analogue side
   // ---------------------------------------------------------------
   assign supervisorTight = cfgOne_q[POS_TIGHT];
   assign overvoltageMonitorEn = supervisorTight && !monitorBlank;
   assign undervoltageLockoutSel = cfgOne_q[POS_LOCKOUT +: 2];
   assign lockoutHysteresisSel = cfgTwo_q[POS_HYS];
   assign railPairWarmReset = cfgTwo_q[POS_WARMRST] && gpPinTwoIn;
   assign gpPinTwoIsOutput = !cfgTwo_q[POS_WARMRST];
   assign switchCurrentLimitSel = cfgTwo_q[POS_ILIM +: 2];
   assign switchOn = switchEnable && !(cfgThree_q[POS_PFDIS] && !powerfail_out_n);
   assign switchDischarge = cfgThree_q[POS_DISCH] && !switchOn;
   assign pulseSkipEn = {buck_q[3][POS_SKIP], buck_q[2][POS_SKIP],
                         buck_q[1][POS_SKIP], buck_q[0][POS_SKIP]};
   assign buckOneTarget = targetOne_q;
   assign buckTwoTarget = targetTwo_q;
   assign buckThreeCode = buck_q[2][5:0];
   // reserved buck-boost codes are not protected here, host keeps off them
   assign buckboostCode = buck_q[3][5:0];

   // ---------------------------------------------------------------
   // read path, registered
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         regRdata <= 8'h00;
         regAck <= 1'b0;
      end else if (clkEn) begin
         regAck <= regStrobe;
         case (regReq.addr)
            OFS_CFG_ONE: regRdata <= cfgOne_q;
            OFS_CFG_TWO: regRdata <= cfgTwo_q;
            OFS_CFG_THREE: regRdata <= cfgThree_q;
            OFS_BUCK_ONE, OFS_BUCK_TWO, OFS_BUCK_THREE, OFS_BUCKBOOST:
               regRdata <= buck_q[buck_slot(regReq.addr)];
            OFS_SLEW: regRdata <= slew_q;
            default: regRdata <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_blank_on_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
      buckWr |=> monitorBlank) else $error("blanking missing after voltage write");
   chk_locked_no_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regStrobe && regReq.wr && !unlocked && clkEn && regReq.addr == OFS_BUCK_THREE
       && strapDone_q) |=> $stable(buck_q[2])) else $error("locked write changed register");
   chk_pg_fall_now: assert property (@(posedge clk_sys) disable iff (sys_rst)
      railFault |-> !powerGood) else $error("power good held during fault");
   chk_pg_no_jump: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(railsInRegulation) |-> !powerGood) else $error("power good rose without delay");
   chk_switch_pf: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cfgThree_q[POS_PFDIS] && !powerfail_out_n) |-> !switchOn) else $error("switch on in fail");
   chk_discharge_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
      switchDischarge |-> (!switchOn && cfgThree_q[POS_DISCH])) else $error("bad discharge");
   chk_hold_target: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clkEn && !slew_q[POS_GO] && !slew_q[POS_AUTO]) |=> $stable(targetOne_q))
      else $error("target moved without trigger");
   chk_go_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clkEn && transitionDone && !(wrAcc && regReq.addr == OFS_SLEW)) |=> !slew_q[POS_GO])
      else $error("trigger stuck");
   chk_ro_bit_six: assert property (@(posedge clk_sys) disable iff (sys_rst)
      buck_q[0][6] == 1'b0) else $error("reserved bit set");
   chk_ov_supervisor_tight_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !cfgOne_q[POS_TIGHT] |-> !overvoltageMonitorEn) else $error("ov monitored when loose");

   // ---------------------------------------------------------------
   // power-good checks
   // ---------------------------------------------------------------
   // a rise must come out of the delay state, never straight back from a fault
   chk_pg_rise_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(powerGood) |-> $past(pgState_q) == PG_WAIT)
      else $error("power good rose without the delay state");
   // outside the high state the output stays low
   chk_pg_low_state: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (pgState_q != PG_HIGH) |-> !powerGood) else $error("power good high outside high state");

   // ---------------------------------------------------------------
   // register path checks
   // ---------------------------------------------------------------
   // reserved pair of the switch limit register answers as zero
   chk_cfg_two_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regStrobe && clkEn && regReq.addr == OFS_CFG_TWO)
      |=> (regAck && regRdata[5:4] == 2'b00)) else $error("reserved bits read back set");
   // reserved read-only fields never hold a one
   chk_ro_fields: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cfgTwo_q[5:4] == 2'b00 && cfgThree_q[7:6] == 2'b00 && slew_q[5:3] == 3'b000)
      else $error("reserved field set");
   // pulse-skip follows the written bit on the next cycle, no trigger needed
   chk_skip_now: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (buckWr && strapDone_q && regReq.addr == OFS_BUCK_ONE)
      |=> pulseSkipEn[0] == $past(regReq.data[POS_SKIP])) else $error("pulse-skip late");
   // after the strap cycle buck three moves only on a write
   chk_strap_once: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (strapDone_q && !buckWr) |=> $stable(buck_q[2])) else $error("buck three moved");
   // auto mode copies the stored codes straight through
   chk_auto_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clkEn && slew_q[POS_AUTO]) |=> (targetOne_q == $past(buck_q[0][5:0])
      && targetTwo_q == $past(buck_q[1][5:0]))) else $error("auto target lagging");
   // the blanking counter steps down by one when left alone
   chk_blank_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (clkEn && !buckWr && blankCnt_q != 0) |=> blankCnt_q == $past(blankCnt_q) - 32'd1)
      else $error("blanking count skipped");

   // ---------------------------------------------------------------
   // pin and switch checks
   // ---------------------------------------------------------------
   // with the select low pin two is a plain output, no warm reset
   chk_warm_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !cfgTwo_q[POS_WARMRST] |-> (gpPinTwoIsOutput && !railPairWarmReset))
      else $error("warm reset while pin is output");
   // with the fail disable low the switch follows its enable
   chk_switch_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !cfgThree_q[POS_PFDIS] |-> switchOn == switchEnable) else $error("switch cut wrongly");
   // discharge runs whenever enabled and the switch is off
   chk_discharge_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cfgThree_q[POS_DISCH] && !switchOn) |-> switchDischarge) else $error("no discharge");

endmodule

/* test/pmic_rail_config_registers_bench.sv */
// self-checking bench for the rail configuration register bank
// assumes the host model delivers accesses; the bench shortens the counts by parameter
`timescale 1ns/100ps

module pmic_rail_config_registers_bench;
   import rail_cfg_pkg::*;
   // -------------------------------------------------------------
   // signals
   // -------------------------------------------------------------
   localparam int MSC = 4;
   typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} row_s;
   logic clk_sys, sys_rst, clkEn, regStrobe, unlocked, regAck, resistorValid;
   logic transitionDone, transitionStart, railsInRegulation, railFault, powerfail_out_n;
   logic switchEnable, gpPinTwoIn, powerGood, monitorBlank, overvoltageMonitorEn;
   logic supervisorTight, lockoutHysteresisSel, switchOn, switchDischarge;
   logic railPairWarmReset, gpPinTwoIsOutput;
   logic [1:0] undervoltageLockoutSel, switchCurrentLimitSel;
   logic [3:0] pulseSkipEn;
   logic [5:0] resistorBuckThree, resistorBuckBoost, buckOneTarget, buckTwoTarget;
   logic [5:0] buckThreeCode, buckboostCode;
   logic [7:0] regRdata;
   reg_req_s regReq;
   int bad_count = 0;
   int checks = 0;
   int n;
   int lim;
   int pgMs[4] = '{PG_MS_0, PG_MS_1, PG_MS_2, PG_MS_3};
   // reset reads, then writes with masked read-back; bb code stays legal
   row_s rows[14] = '{
      '{1'b0, 8'h13, 8'h00, 8'h4c}, '{1'b0, 8'h14, 8'h00, 8'hc0}, '{1'b0, 8'h15, 8'h00, 8'h00},
      '{1'b0, 8'h16, 8'h00, 8'h99}, '{1'b0, 8'h17, 8'h00, 8'h99}, '{1'b0, 8'h18, 8'h00, 8'h8c},
      '{1'b0, 8'h19, 8'h00, 8'hb2}, '{1'b0, 8'h1a, 8'h00, 8'h06}, '{1'b0, 8'h1b, 8'h00, 8'h00},
      '{1'b1, 8'h14, 8'hff, 8'hcf}, '{1'b1, 8'h15, 8'hff, 8'h3f}, '{1'b1, 8'h18, 8'hff, 8'hbf},
      '{1'b1, 8'h19, 8'h74, 8'h34}, '{1'b1, 8'h1b, 8'h55, 8'h00}};

   rail_config_regs #(.BLANK_CYCLES(20), .MS_CYCLES(MSC)) i_rail_config_regs (.clk_sys,
      .sys_rst, .clkEn, .regReq, .regStrobe, .unlocked, .regRdata, .regAck, .resistorValid,
      .resistorBuckThree, .resistorBuckBoost, .transitionDone, .transitionStart,
      .railsInRegulation, .railFault, .powerfail_out_n, .switchEnable, .gpPinTwoIn,
      .powerGood, .monitorBlank, .overvoltageMonitorEn, .supervisorTight,
      .undervoltageLockoutSel, .lockoutHysteresisSel, .switchCurrentLimitSel, .switchOn,
      .switchDischarge, .railPairWarmReset, .gpPinTwoIsOutput, .pulseSkipEn, .buckOneTarget,
      .buckTwoTarget, .buckThreeCode, .buckboostCode);

   rail_host_model i_rail_host_model (.clk_sys, .regReq, .regStrobe, .unlocked, .regRdata,
      .regAck);

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic tick();
      @(negedge clk_sys);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic k;
      i_rail_host_model.access(1'b1, a, d, r, k);
      chk(k, 1'b1, "write ack");
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      logic k;
      i_rail_host_model.access(1'b0, a, 8'h00, r, k);
      chk(k, 1'b1, "read ack");
      chk(r, e, "read data");
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // hang guard, well beyond the expected run length
   initial begin
      #(8 * 6000);
      bad_count++;
      print_verdict();
   end

   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      clkEn = 1'b1;
      resistorValid = 1'b0;
      resistorBuckThree = 6'h00;
      resistorBuckBoost = 6'h00;
      transitionDone = 1'b0;
      railsInRegulation = 1'b0;
      railFault = 1'b0;
      powerfail_out_n = 1'b1;
      switchEnable = 1'b0;
      gpPinTwoIn = 1'b1;
      repeat (5) tick();
      sys_rst = 1'b0;
      repeat (2) tick();
      chk(pulseSkipEn, 4'hf, "skip reset");
      chk({supervisorTight, lockoutHysteresisSel, railPairWarmReset}, 3'b111, "cfg reset");
      chk({switchCurrentLimitSel, undervoltageLockoutSel}, 4'h0, "field reset");
      chk({buckOneTarget, buckThreeCode}, 12'h64c, "code reset");
      chk(buckboostCode, 6'h32, "bb reset");
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].data);
         rd(rows[i].addr, rows[i].exp);
      end
      chk(pulseSkipEn, 4'b0111, "skip after writes");
      // switch limit codes, pin two as plain output
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CFG_TWO, 8'(i << POS_ILIM));
         chk({switchCurrentLimitSel, gpPinTwoIsOutput, railPairWarmReset}, {i[1:0], 2'b10}, "ilim");
      end
      // power-fail cut-off and discharge of the load switch
      wr(OFS_CFG_THREE, 8'h20);
      switchEnable = 1'b1;
      powerfail_out_n = 1'b0;
      #1 chk(switchOn, 1'b0, "pf cut");
      wr(OFS_CFG_THREE, 8'h04);
      chk({switchOn, switchDischarge}, 2'b10, "pf ignored");
      switchEnable = 1'b0;
      #1 chk(switchDischarge, 1'b1, "discharge");
      wr(OFS_CFG_ONE, 8'h03);
      chk({supervisorTight, overvoltageMonitorEn, undervoltageLockoutSel}, 4'h3, "loose");
      // blanking after a voltage write; no move without go or auto
      wr(OFS_CFG_ONE, 8'h04);
      wr(OFS_BUCK_ONE, 8'h05);
      chk({monitorBlank, overvoltageMonitorEn, pulseSkipEn[0]}, 3'b100, "blank on");
      repeat (10) tick();
      chk(monitorBlank, 1'b1, "blank held");
      repeat (20) tick();
      chk({monitorBlank, overvoltageMonitorEn}, 2'b01, "blank off");
      chk(buckOneTarget, 6'h19, "no move");
      // trigger move, self-clear on done
      wr(OFS_SLEW, 8'h80);
      chk(transitionStart, 1'b1, "start");
      repeat (2) tick();
      chk(buckOneTarget, 6'h05, "go move");
      transitionDone = 1'b1;
      tick();
      transitionDone = 1'b0;
      rd(OFS_SLEW, 8'h00);
      wr(OFS_BUCK_ONE, 8'h86);
      repeat (2) tick();
      chk(buckOneTarget, 6'h05, "held after done");
      wr(OFS_SLEW, 8'h40);
      wr(OFS_BUCK_TWO, 8'h3f);
      repeat (2) tick();
      chk(buckTwoTarget, 6'h3f, "auto move");
      // locked writes are dropped
      i_rail_host_model.set_unlock(1'b0);
      wr(OFS_BUCK_THREE, 8'h00);
      i_rail_host_model.set_unlock(1'b1);
      rd(OFS_BUCK_THREE, 8'hbf);
      // power-good delay per code, immediate fall
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CFG_ONE, 8'(i << POS_PG_DELAY) | 8'h04);
         railsInRegulation = 1'b1;
         lim = pgMs[i] * MSC;
         n = 0;
         while (powerGood !== 1'b1 && n < 700) begin
            tick();
            n++;
         end
         chk(n inside {[lim - 2 : lim + 2]}, 1'b1, "pg delay");
         railFault = 1'b1;
         #1 chk(powerGood, 1'b0, "pg fall");
         railFault = 1'b0;
         railsInRegulation = 1'b0;
         tick();
      end
      // defaults from the selection resistor
      sys_rst = 1'b1;
      resistorValid = 1'b1;
      resistorBuckThree = 6'h2a;
      resistorBuckBoost = 6'h21;
      repeat (5) tick();
      sys_rst = 1'b0;
      repeat (3) tick();
      chk({buckThreeCode, buckboostCode}, 12'haa1, "strap codes");
      rd(OFS_BUCKBOOST, 8'ha1);
      print_verdict();
   end
endmodule

/* test/rail_host_model.sv */
// host model standing on the far side of the register port
// assumes the bench calls its task; inputs change on falling edges only
`timescale 1ns/100ps

module rail_host_model
   import rail_cfg_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // register access
   output reg_req_s regReq,
   output logic regStrobe,
   output logic unlocked,
   input wire logic [7:0] regRdata,
   input wire logic regAck
);
   // -------------------------------------------------------------
   // idle state
   // -------------------------------------------------------------
   // unlock is done before any protected write, so it idles high
   initial begin
      regReq = '0;
      regStrobe = 1'b0;
      unlocked = 1'b1;
   end

   // -------------------------------------------------------------
   // bus cycle
   // -------------------------------------------------------------
   // one-cycle strobe; answer taken mid-cycle, after the taking edge
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                         output logic [7:0] rdata, output logic ack);
      @(negedge clk_sys);
      regReq = '{wr: wr, addr: addr, data: data};
      regStrobe = 1'b1;
      @(negedge clk_sys);
      regStrobe = 1'b0;
      // released request shows a changed pattern, never the old one
      regReq = '{wr: 1'b0, addr: ~addr, data: ~data};
      rdata = regRdata;
      ack = regAck;
   endtask

   // unlock level, changed by the bench between accesses only
   task automatic set_unlock(input logic level);
      unlocked = level;
   endtask
endmodule
